// [verilog/esrb_defines.svh]
// Purpose: Offsets, field positions and reset values for the exception status bank
// Assumes: APB byte addresses are four times the register index
// Notes:   Definitions only
`ifndef ESRB_DEFINES_SVH
`define ESRB_DEFINES_SVH
// Register indices
`define ESRB_IDX_SYSSTAT    12'h130
`define ESRB_IDX_ACTMASK    12'h133
`define ESRB_IDX_LATCLR     12'h134
`define ESRB_IDX_OVERLAY    12'h135
`define ESRB_IDX_EXCSTAT    12'h136
`define ESRB_IDX_LATSEL     12'h137
`define ESRB_IDX_MASKT1     12'h138
`define ESRB_IDX_MASKT2     12'h139
`define ESRB_IDX_MASKAMP    12'h13a
`define ESRB_IDX_DIAG       12'h13b
// Field positions
`define ESRB_BIT_USER1      16
`define ESRB_BIT_USER2      17
`define ESRB_BIT_USER3      18
`define ESRB_BIT_RUNERR1    19
// Masks and reset values
`define ESRB_USER_MASK      24'h070000
`define ESRB_ACTMASK_VALID  24'h0001fd
`define ESRB_LATSEL_RST     24'h070000
`define ESRB_MASKT1_RST     24'h010000
`define ESRB_MASKT2_RST     24'h020000
`define ESRB_MASKAMP_RST    24'h040000
// Extension bus window
`define ESRB_EXT_LO         16'h0200
`define ESRB_EXT_HI         16'hefff
`endif

// [verilog/esrb_pkg.sv]
// Purpose: Types for the exception status bank
// Assumes: 24-bit integer registers
// Notes:   Numbers live in esrb_defines.svh
package esrb_pkg;
    typedef logic [23:0] esrb_int_type;   // Integer register word
    typedef logic [47:0] esrb_long_type;  // Long variable word
    typedef struct packed {
        esrb_int_type excStat;   // Exception status
        esrb_int_type latSel;    // Latch selection
        esrb_int_type maskT1;    // Task one stop mask
        esrb_int_type maskT2;    // Task two stop mask
        esrb_int_type maskAmp;   // Amplifier off mask
        logic [31:0]  prdata;    // Read data
        logic         pready;    // Access done
        logic         pslverr;   // Error answer
        logic         stopT1;    // Stop task one
        logic         stopT2;    // Stop task two
        logic         ampOff;    // Amplifier off
        logic         extSel;    // Extension bus hit
    } esrb_state_type;
endpackage

// [verilog/exception_status_register_bank.sv]
// Purpose: Status word, active masks and latched exception store on APB
// Assumes: Inputs synchronous to sys_clk; srst synchronous active high
// Notes:   One-wait-state APB slave; unmapped addresses answer pslverr
`timescale 1ns/1ps
`include "esrb_defines.svh"

module exception_status_register_bank
    import esrb_pkg::*;
(
    input  wire logic         sys_clk,      // System clock
    input  wire logic         srst,         // Synchronous reset
    input  wire logic         psel,         // APB select
    input  wire logic         penable,      // APB enable
    input  wire logic         pwrite,       // APB direction
    input  wire logic [15:0]  paddr,        // APB byte address
    input  wire logic [31:0]  pwdata,       // APB write data
    output logic [31:0]       prdata,       // APB read data
    output logic              pready,       // APB ready
    output logic              pslverr,      // APB error
    input  wire logic [23:16] statusIn,     // Upper status bits
    input  wire logic [15:0]  statusLow,    // Lower status bits
    input  wire logic [8:0]   maskActive,   // Active mask levels
    input  wire esrb_int_type excDetect,    // Detected exceptions
    input  wire logic         task1Running, // Task one runs
    input  wire logic         task2Running, // Task two runs
    input  wire logic         indexFault1,  // Index out of range in task one
    input  wire logic [15:0]  portAddr,     // Port variable address
    output logic              stopTask1,    // Stop and exit task one
    output logic              stopTask2,    // Stop and exit task two
    output logic              ampDisable,   // Amplifier off
    output logic              extBusSel     // Port address on extension bus
);

    // Limitations a user should know:
    // - Status bits 16 to 23 are shown as presented, never computed here.
    // - Non-latched exceptions follow detection one clock late; a slow
    //   reader may miss a short one, so latch those that matter.
    // - Stop and amplifier outputs lag the exception bit by one clock.
    // - Bits 31 to 24 of every write are dropped: registers are 24 bits.

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Byte address of a register index
    function automatic logic [15:0] regAddr(input logic [11:0] idx);
        regAddr = {2'h0, idx, 2'h0};
    endfunction

    // Widen a 24-bit integer to the 32-bit bus, upper bits zero
    function automatic logic [31:0] widen(input esrb_int_type v);
        widen = {8'h00, v};
    endfunction

    // ------------------------------------------------------------
    // State and working signals
    // ------------------------------------------------------------
    esrb_state_type state_reg;   // All state
    esrb_state_type state_next;  // Next state
    logic           setup;       // Setup phase seen
    logic           wrHit;       // Write accepted this edge
    logic           rdHit;       // Read accepted this edge
    esrb_int_type   sysWord;     // Assembled status word
    esrb_int_type   actWord;     // Assembled mask view
    esrb_int_type   setVec;      // Exceptions set this cycle
    esrb_int_type   clrVec;      // Latches cleared this cycle
    logic           mapped;      // Address decodes
    logic [31:0]    rdVal;       // Decoded read value

    // ------------------------------------------------------------
    // Combinational next state
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        // Bus phase decode: a transfer is taken only when ready stands
        setup = psel && !penable;
        wrHit = psel && penable && state_reg.pready && pwrite;
        rdHit = psel && penable && state_reg.pready && !pwrite;

        // ----------------------------------------
        // Status and mask views
        // ----------------------------------------
        // Lower half passes through untouched
        sysWord[15:0]  = statusLow;
        // Calibration, trigger hold, loop mode, homing
        sysWord[19:16] = statusIn[19:16];
        // Filter, loop broken, pause sent, request busy
        sysWord[23:20] = statusIn[23:20];
        // Mask view, reserved bits forced low
        actWord = {15'h0000, maskActive} & `ESRB_ACTMASK_VALID;

        // ----------------------------------------
        // Exception set and clear vectors
        // ----------------------------------------
        // Detection plus overlay user bits plus task one index fault
        setVec = excDetect;
        // Overlay write: only the three user bits get through
        if (wrHit && paddr == regAddr(`ESRB_IDX_OVERLAY)) begin
            setVec = setVec | (pwdata[23:0] & `ESRB_USER_MASK);
        end
        // Out-of-range index only counts while task one runs
        if (indexFault1 && task1Running) begin
            setVec[`ESRB_BIT_RUNERR1] = 1'b1;
        end
        // Clear only where a one is written
        clrVec = 24'h000000;
        if (wrHit && paddr == regAddr(`ESRB_IDX_LATCLR)) begin
            clrVec = pwdata[23:0];
        end

        // ----------------------------------------
        // Exception latches
        // ----------------------------------------
        // Latched bits hold until cleared; others follow detection.
        // A set in the same clock as a clear wins, so an exception
        // still present is never lost to a late reset write.
        state_next.excStat = (setVec & ~state_reg.latSel)
                           | (state_reg.latSel
                              & ((state_reg.excStat & ~clrVec) | setVec));

        // ----------------------------------------
        // Configuration writes
        // ----------------------------------------
        // Latch selection, all 24 bits writable
        if (wrHit && paddr == regAddr(`ESRB_IDX_LATSEL)) begin
            state_next.latSel = pwdata[23:0];
        end
        // Task one stop mask
        if (wrHit && paddr == regAddr(`ESRB_IDX_MASKT1)) begin
            state_next.maskT1 = pwdata[23:0];
        end
        // Task two stop mask
        if (wrHit && paddr == regAddr(`ESRB_IDX_MASKT2)) begin
            state_next.maskT2 = pwdata[23:0];
        end
        // Amplifier off mask
        if (wrHit && paddr == regAddr(`ESRB_IDX_MASKAMP)) begin
            state_next.maskAmp = pwdata[23:0];
        end

        // ----------------------------------------
        // Exception actions
        // ----------------------------------------
        // Stops only matter while the task runs; the amplifier always
        state_next.stopT1 = |(state_reg.excStat & state_reg.maskT1) && task1Running;
        // A run-time error in task one exits it whatever the mask says
        if (state_reg.excStat[`ESRB_BIT_RUNERR1] && task1Running) begin
            state_next.stopT1 = 1'b1;
        end
        state_next.stopT2 = |(state_reg.excStat & state_reg.maskT2) && task2Running;
        state_next.ampOff = |(state_reg.excStat & state_reg.maskAmp);
        // Extension bus window decode, both ends inside
        state_next.extSel = (portAddr >= `ESRB_EXT_LO) && (portAddr <= `ESRB_EXT_HI);

        // ----------------------------------------
        // Read decode
        // ----------------------------------------
        // Any address not listed answers with an error
        mapped = 1'b1;
        rdVal = 32'h00000000;
        case (paddr)
            regAddr(`ESRB_IDX_SYSSTAT): begin
                rdVal = widen(sysWord);
            end
            regAddr(`ESRB_IDX_ACTMASK): begin
                rdVal = widen(actWord);
            end
            regAddr(`ESRB_IDX_LATCLR),
            regAddr(`ESRB_IDX_OVERLAY): begin
                rdVal = 32'h00000000; // Write-only ports read zero
            end
            regAddr(`ESRB_IDX_EXCSTAT): begin
                rdVal = widen(state_reg.excStat);
            end
            regAddr(`ESRB_IDX_LATSEL): begin
                rdVal = widen(state_reg.latSel);
            end
            regAddr(`ESRB_IDX_MASKT1): begin
                rdVal = widen(state_reg.maskT1);
            end
            regAddr(`ESRB_IDX_MASKT2): begin
                rdVal = widen(state_reg.maskT2);
            end
            regAddr(`ESRB_IDX_MASKAMP): begin
                rdVal = widen(state_reg.maskAmp);
            end
            regAddr(`ESRB_IDX_DIAG): begin
                rdVal = {29'h00000000, state_reg.ampOff, state_reg.stopT2, state_reg.stopT1};
            end
            default: begin
                mapped = 1'b0; // Unmapped address
            end
        endcase

        // ----------------------------------------
        // Bus answer
        // ----------------------------------------
        // One wait state: ready rises after the first access cycle.
        // The read value is captured then and held until the next
        // access, so a slow master still sees settled data.
        state_next.pready = 1'b0;
        state_next.pslverr = 1'b0;
        if (psel && penable && !state_reg.pready) begin
            state_next.pready = 1'b1;
            state_next.pslverr = !mapped;
            state_next.prdata = pwrite ? 32'h00000000 : rdVal;
        end
        if (setup || rdHit) begin
            state_next.prdata = state_reg.prdata;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        // Reset clears everything, then loads the factory defaults
        if (srst) begin
            state_reg <= '0;
            state_reg.latSel  <= `ESRB_LATSEL_RST;
            state_reg.maskT1  <= `ESRB_MASKT1_RST;
            state_reg.maskT2  <= `ESRB_MASKT2_RST;
            state_reg.maskAmp <= `ESRB_MASKAMP_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Outputs straight from flip-flops, no logic after the register
    assign prdata     = state_reg.prdata;
    assign pready     = state_reg.pready;
    assign pslverr    = state_reg.pslverr;
    assign stopTask1  = state_reg.stopT1;
    assign stopTask2  = state_reg.stopT2;
    assign ampDisable = state_reg.ampOff;
    assign extBusSel  = state_reg.extSel;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Taken write to the latch reset port
    sequence s_clrWrite;
        psel && penable && pready && pwrite && paddr == regAddr(`ESRB_IDX_LATCLR);
    endsequence

    // Taken write to the overlay port
    sequence s_ovlWrite;
        psel && penable && pready && pwrite && paddr == regAddr(`ESRB_IDX_OVERLAY);
    endsequence

    // Index fault taken, and task one still running a clock later
    sequence s_faultSeen;
        (indexFault1 && task1Running) ##1 task1Running;
    endsequence

    // Status read returns the upper status levels
    a_sys_read_bits: assert property (@(posedge sys_clk) disable iff (srst)
        (psel && penable && !pready && !pwrite && paddr == regAddr(`ESRB_IDX_SYSSTAT))
        |=> prdata[23:16] == $past(statusIn))
        else $error("status read bits wrong");

    // Mask view mirrors the mask levels
    a_mask_view: assert property (@(posedge sys_clk) disable iff (srst)
        (psel && penable && !pready && !pwrite && paddr == regAddr(`ESRB_IDX_ACTMASK))
        |=> prdata[8:0] == ($past(maskActive) & 9'h1fd))
        else $error("mask view wrong");

    // Reserved mask bits read zero
    a_mask_reserved: assert property (@(posedge sys_clk) disable iff (srst)
        (psel && penable && !pready && !pwrite && paddr == regAddr(`ESRB_IDX_ACTMASK))
        |=> prdata[31:9] == 23'h000000 && prdata[1] == 1'b0)
        else $error("reserved mask bit set");

    // A latched bit survives until a reset write hits it
    a_sticky_hold: assert property (@(posedge sys_clk) disable iff (srst)
        (state_reg.excStat[`ESRB_BIT_USER1] && state_reg.latSel[`ESRB_BIT_USER1]
         && !(wrHit && paddr == regAddr(`ESRB_IDX_LATCLR) && pwdata[`ESRB_BIT_USER1]))
        |=> state_reg.excStat[`ESRB_BIT_USER1])
        else $error("latched bit lost");

    // A one in the reset port clears an idle exception
    a_clear_one: assert property (@(posedge sys_clk) disable iff (srst)
        (s_clrWrite and (pwdata[`ESRB_BIT_USER3] && !excDetect[`ESRB_BIT_USER3]))
        |=> !state_reg.excStat[`ESRB_BIT_USER3])
        else $error("clear did not clear");

    // A zero in the reset port leaves the latch alone
    a_clear_zero: assert property (@(posedge sys_clk) disable iff (srst)
        (s_clrWrite and (!pwdata[`ESRB_BIT_USER2] && state_reg.excStat[`ESRB_BIT_USER2]
         && state_reg.latSel[`ESRB_BIT_USER2])) |=> state_reg.excStat[`ESRB_BIT_USER2])
        else $error("zero write changed bit");

    // Overlay ones raise the user bits
    a_overlay_set: assert property (@(posedge sys_clk) disable iff (srst)
        (s_ovlWrite and pwdata[`ESRB_BIT_USER2]) |=> state_reg.excStat[`ESRB_BIT_USER2])
        else $error("overlay did not set");

    // Overlay bits outside the user field do nothing
    a_overlay_other: assert property (@(posedge sys_clk) disable iff (srst)
        (s_ovlWrite and (excDetect[0] == 1'b0) and (state_reg.latSel[0] == 1'b0))
        |=> !state_reg.excStat[0])
        else $error("overlay set other bit");

    // Task one stops on its masked user exception
    a_stop_task1: assert property (@(posedge sys_clk) disable iff (srst)
        (state_reg.excStat[`ESRB_BIT_USER1] && state_reg.maskT1[`ESRB_BIT_USER1] && task1Running)
        |=> stopTask1)
        else $error("task one not stopped");

    // Amplifier goes off on its masked user exception
    a_amp_off: assert property (@(posedge sys_clk) disable iff (srst)
        (state_reg.excStat[`ESRB_BIT_USER3] && state_reg.maskAmp[`ESRB_BIT_USER3])
        |=> ampDisable)
        else $error("amplifier not disabled");

    // Index fault in a running task one sets the error bit
    a_index_fault: assert property (@(posedge sys_clk) disable iff (srst)
        (indexFault1 && task1Running) |=> state_reg.excStat[`ESRB_BIT_RUNERR1])
        else $error("run error bit not set");

    // Addresses just outside the window do not decode
    a_ext_window: assert property (@(posedge sys_clk) disable iff (srst)
        (portAddr == 16'h01ff || portAddr == 16'hf000) |=> !extBusSel)
        else $error("extension window wrong");

    // Task two stops on its masked user exception
    a_stop_task2: assert property (@(posedge sys_clk) disable iff (srst)
        (state_reg.excStat[`ESRB_BIT_USER2] && state_reg.maskT2[`ESRB_BIT_USER2] && task2Running)
        |=> stopTask2)
        else $error("task two not stopped");

    // Run-time error exits task one two clocks after the fault
    a_index_exit: assert property (@(posedge sys_clk) disable iff (srst)
        s_faultSeen |=> stopTask1)
        else $error("task one not exited");

    // Read answers never carry bits above the 24-bit word
    a_upper_zero: assert property (@(posedge sys_clk) disable iff (srst)
        (psel && penable && !pready && !pwrite) |=> prdata[31:24] == 8'h00)
        else $error("upper read bits set");

    // Both window ends decode as extension bus
    a_ext_inside: assert property (@(posedge sys_clk) disable iff (srst)
        (portAddr == `ESRB_EXT_LO || portAddr == `ESRB_EXT_HI) |=> extBusSel)
        else $error("extension window end missed");

endmodule // exception_status_register_bank

// [testbench/esrb_task_model.sv]
// Purpose: Program task model seen by the exception status bank
// Assumes: Start requests and stop commands sampled on sys_clk
// Notes:   A stopped task stays idle until started again
`timescale 1ns/1ps

module esrb_task_model (
    input  wire logic       sys_clk,      // System clock
    input  wire logic       srst,         // Synchronous reset
    input  wire logic [1:0] startTask,    // Start request per task
    input  wire logic       stopTask1,    // Stop and exit task one
    input  wire logic       stopTask2,    // Stop and exit task two
    output logic            task1Running, // Task one runs
    output logic            task2Running  // Task two runs
);
    // ----------------------------------------
    // Task run state
    // ----------------------------------------
    // Stop wins over start, but the bank raises stop only while a task runs, so a pending exception lets it run two clocks
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            task1Running <= 1'b0;
            task2Running <= 1'b0;
        end else begin
            task1Running <= (task1Running | startTask[0]) & ~stopTask1;
            task2Running <= (task2Running | startTask[1]) & ~stopTask2;
        end
    end
endmodule // esrb_task_model

// [testbench/exception_status_register_bank_test.sv]
// Purpose: Register-level checks of the exception status bank
// Assumes: APB byte address is four times the register index
// Notes:   Task model stands in for the program tasks
`timescale 1ns/1ps
`include "esrb_defines.svh"

module exception_status_register_bank_test
    import esrb_pkg::*;
;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic         sysClk, srst, psel, penable, pwrite, pready, pslverr;  // Clock, reset, bus
    logic [15:0]  paddr;                                             // Byte address
    logic [31:0]  pwdata, prdata;                                    // Bus data
    logic [23:16] statusIn;                                          // Upper status
    logic [15:0]  statusLow, portAddr;                               // Lower status, port
    logic [8:0]   maskActive;                                        // Mask levels
    esrb_int_type excDetect;                                         // Detected exceptions
    logic         task1Running, task2Running, indexFault1;           // Task side
    logic         stopTask1, stopTask2, ampDisable, extBusSel;       // Actions
    logic [1:0]   startTask;                                         // Task start pulses
    int           numErrors, samplesChecked;                         // Counters
    logic [15:0]  extAddr [4] = '{16'h01ff, 16'h0200, 16'hefff, 16'hf000}; // Window edges
    logic         extExp  [4] = '{1'b0, 1'b1, 1'b1, 1'b0};               // Expected hits

    exception_status_register_bank exception_status_register_bank_i (
        .sys_clk(sysClk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .statusIn(statusIn), .statusLow(statusLow), .maskActive(maskActive),
        .excDetect(excDetect), .task1Running(task1Running), .task2Running(task2Running),
        .indexFault1(indexFault1), .portAddr(portAddr), .stopTask1(stopTask1),
        .stopTask2(stopTask2), .ampDisable(ampDisable), .extBusSel(extBusSel));
    esrb_task_model esrb_task_model_i (
        .sys_clk(sysClk), .srst(srst), .startTask(startTask), .stopTask1(stopTask1),
        .stopTask2(stopTask2), .task1Running(task1Running), .task2Running(task2Running));

    // ----------------------------------------
    // Clock and shared tasks
    // ----------------------------------------
    initial begin
        sysClk = 1'b0;
        forever #5 sysClk = ~sysClk;
    end

    // Closing report
    task automatic giveVerdict();
        $display("Comparisons %0d, mismatches %0d", samplesChecked, numErrors);
        if (numErrors == 0 && samplesChecked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            numErrors++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer, entered just after a rising edge
    task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= wd;
        @(posedge sysClk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sysClk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            numErrors++;
            $display("FAIL at %0t: got %h expected %h", $time, pready, 1'b1);
            giveVerdict();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge sysClk);
    endtask

    // Write with no answer check
    task automatic wreg(input logic [11:0] idx, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, idx, d, r, e);
    endtask

    // Read and compare, expecting no error answer
    task automatic rchk(input logic [11:0] idx, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, idx, 32'h0, r, e);
        check(r, exp);
        check({31'h0, e}, 32'h0);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [31:0] want; // Expected status word
        logic [31:0] r;
        logic        e;
        {srst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 51'h0};
        {statusIn, statusLow, maskActive, excDetect} = 57'h0;
        {indexFault1, portAddr, startTask} = 19'h0;
        numErrors = 0;
        samplesChecked = 0;
        repeat (20) @(posedge sysClk);
        srst <= 1'b0;
        @(posedge sysClk);
        rchk(`ESRB_IDX_LATSEL, 32'h00070000);
        rchk(`ESRB_IDX_MASKT1, 32'h00010000);
        rchk(`ESRB_IDX_MASKT2, 32'h00020000);
        rchk(`ESRB_IDX_MASKAMP, 32'h00040000);
        // Status word with complementary patterns
        for (int i = 0; i < 2; i++) begin
            statusIn  <= 8'ha5 ^ {8{i[0]}};
            statusLow <= 16'h1234 ^ {16{i[0]}};
            repeat (2) @(posedge sysClk);
            want = {8'h0, 8'ha5 ^ {8{i[0]}}, 16'h1234 ^ {16{i[0]}}};
            rchk(`ESRB_IDX_SYSSTAT, want);
            rchk(`ESRB_IDX_SYSSTAT, want);
        end
        // Active masks, reserved bit and write ignored
        maskActive <= 9'h1ff;
        wreg(`ESRB_IDX_ACTMASK, 32'hffffffff);
        rchk(`ESRB_IDX_ACTMASK, 32'h000001fd);
        maskActive <= 9'h0aa;
        rchk(`ESRB_IDX_ACTMASK, 32'h000000a8);
        // Extension window edges
        for (int i = 0; i < 4; i++) begin
            portAddr <= extAddr[i];
            repeat (3) @(posedge sysClk);
            @(negedge sysClk);
            check({31'h0, extBusSel}, {31'h0, extExp[i]});
            @(posedge sysClk);
        end
        // Mask write keeps 24 bits only, value left at its default
        wreg(`ESRB_IDX_MASKT1, 32'hff010000);
        rchk(`ESRB_IDX_MASKT1, 32'h00010000);
        // User exceptions through overlay stop tasks and amplifier
        startTask <= 2'b11;
        @(posedge sysClk);
        startTask <= 2'b00;
        wreg(`ESRB_IDX_OVERLAY, 32'hffffffff);
        repeat (4) @(posedge sysClk);
        @(negedge sysClk);
        check({30'h0, task2Running, task1Running}, 32'h0);
        check({31'h0, ampDisable}, 32'h1);
        @(posedge sysClk);
        rchk(`ESRB_IDX_EXCSTAT, 32'h00070000);
        rchk(`ESRB_IDX_DIAG, 32'h00000004);
        wreg(`ESRB_IDX_LATCLR, 32'h00010000);
        rchk(`ESRB_IDX_EXCSTAT, 32'h00060000);
        wreg(`ESRB_IDX_LATCLR, 32'h00060000);
        rchk(`ESRB_IDX_EXCSTAT, 32'h00000000);
        // Non-latched follows detection, latched holds
        excDetect <= 24'h000100;
        repeat (2) @(posedge sysClk);
        rchk(`ESRB_IDX_EXCSTAT, 32'h00000100);
        excDetect <= 24'h000000;
        repeat (2) @(posedge sysClk);
        rchk(`ESRB_IDX_EXCSTAT, 32'h00000000);
        wreg(`ESRB_IDX_LATSEL, 32'h00080100);
        excDetect <= 24'h000100;
        @(posedge sysClk);
        excDetect <= 24'h000000;
        // Index fault while task one runs
        startTask <= 2'b01;
        @(posedge sysClk);
        startTask <= 2'b00;
        indexFault1 <= 1'b1;
        @(posedge sysClk);
        indexFault1 <= 1'b0;
        repeat (2) @(posedge sysClk);
        rchk(`ESRB_IDX_EXCSTAT, 32'h00080100);
        check({31'h0, task1Running}, 32'h0);
        wreg(`ESRB_IDX_LATCLR, 32'h00080100);
        rchk(`ESRB_IDX_EXCSTAT, 32'h00000000);
        // Unmapped address answers with an error
        apb(1'b0, 12'h000, 32'h0, r, e);
        check(r, 32'h0);
        check({31'h0, e}, 32'h1);
        giveVerdict();
    end
endmodule // exception_status_register_bank_test
